// ==== hbi_pkg.sv ====
// shared constants and types of the host port block
package hbi_pkg;
  // register select codes
  localparam logic [2:0] HBI_SEL_EVENT  = 3'h0;
  localparam logic [2:0] HBI_SEL_MASK   = 3'h1;
  localparam logic [2:0] HBI_SEL_CTRL   = 3'h2;
  localparam logic [2:0] HBI_SEL_STATUS = 3'h3;
  // reset values
  localparam logic [7:0] HBI_MASK_RST   = 8'h00;
  localparam logic [7:0] HBI_CTRL_RST   = 8'h00;
  localparam logic [7:0] HBI_SCRATCH_RST = 8'h00;
  // control field positions
  localparam int HBI_CTRL_MODE_LSB = 0;
  localparam int HBI_CTRL_DIV_LSB  = 2;
  // event bit of the hook switch
  localparam int HBI_EV_HOOK = 0;
  // frame period and mclk divider
  localparam int HBI_FRAME_NS  = 125000;
  localparam int HBI_CLK_NS    = 25;
  localparam int HBI_FRAME_CYC = HBI_FRAME_NS / HBI_CLK_NS;
  localparam int HBI_DIV_W     = 8;

  typedef enum logic [1:0] {
    HBI_MODE_IDLE  = 2'b00,
    HBI_MODE_DATA  = 2'b01,
    HBI_MODE_VOICE = 2'b11,
    HBI_MODE_DOWN  = 2'b10
  } hbi_mode_e;

  // host strobes as sampled
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] sel;
    logic [7:0] data;
  } hbi_strobe_s;
endpackage

// ==== hbi_host_port.sv ====
// host port: strobed register access, frame-paced interrupt, hook events
`timescale 1ns/1ps

module hbi_host_port
  import hbi_pkg::*;
#(
  parameter int FRAME_CYC = HBI_FRAME_CYC,
  parameter int NSCRATCH  = 4
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       device_reset,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] register_select,
  input  wire logic [7:0] host_bus_in,
  output logic      [7:0] host_bus_out,
  output logic            host_bus_oe,
  output logic            int_n,
  input  wire logic       hook_switch_in,
  input  wire logic [6:0] event_in,
  output logic            mclk_out,
  output hbi_mode_e       mode_out
);

  // ---------------------------------------------------------------
  // reset and pin sampling
  // ---------------------------------------------------------------
  logic        any_rst;
  hbi_strobe_s pin_now;
  hbi_strobe_s sync1_reg;
  hbi_strobe_s sync2_reg;
  hbi_strobe_s prev_reg;
  logic        hook1_reg;
  logic        hook2_reg;
  logic        hook_prev_reg;
  logic  [2:0] hook_live_reg;

  // both resets act at the next edge; the system reset also holds the
  // clock divider, the device reset does not
  // a strobe already low at release is seen as a fresh access, so hosts
  // should release the strobes before releasing reset
  // device reset acts in the same clock as the system reset
  assign any_rst = !rst_n || device_reset;

  // pins gathered so they cross the sync stages as one word
  assign pin_now = '{cs_n: cs_n,
                     rd_n: rd_n,
                     wr_n: wr_n,
                     sel:  register_select,
                     data: host_bus_in};

  // only the second stage and the edge memory feed the logic; the first may be metastable
  // and nothing else reads it
  // two stages; data and select travel with the strobes so they stay aligned
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      sync1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 3'h0, data: 8'h00};
      sync2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 3'h0, data: 8'h00};
      prev_reg  <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 3'h0, data: 8'h00};
    end else begin
      sync1_reg <= pin_now;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // hook switch synchroniser and edge memory
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      hook1_reg     <= 1'b1;
      hook2_reg     <= 1'b1;
      hook_prev_reg <= 1'b1;
    end else begin
      hook1_reg     <= hook_switch_in;
      hook2_reg     <= hook1_reg;
      hook_prev_reg <= hook2_reg;
    end
  end

  // edge memory is trusted only once the pin has filled all three stages;
  // a switch held low through reset would otherwise look like a change
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      hook_live_reg <= 3'h0;
    end else begin
      hook_live_reg <= {hook_live_reg[1:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic rd_fall;
  logic wr_rise;
  logic hook_edge;
  logic ev_read;

  // latency: a strobe edge at the pins is acted on at the third clock
  // edge after it, two for the synchroniser and one for the edge memory;
  // select and data come from the same sampled word as the strobe,
  // so the host must hold them for three clocks around each edge
  // strobes count only while chip select is low
  assign rd_fall = !sync2_reg.cs_n && prev_reg.rd_n && !sync2_reg.rd_n;
  // rising write edge qualified by the select still low before it
  assign wr_rise = !prev_reg.cs_n && !prev_reg.wr_n && sync2_reg.wr_n;
  // a level seen through reset is not a change, so edges wait for the pipe
  assign hook_edge = hook_live_reg[2] && (hook2_reg ^ hook_prev_reg);
  assign ev_read = rd_fall && (sync2_reg.sel == HBI_SEL_EVENT);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] event_reg;
  logic [7:0] event_next;
  logic [7:0] event_set;
  logic [7:0] mask_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] scratch_reg [NSCRATCH];
  logic [7:0] status_val;
  logic [7:0] read_val;

  // select map: 0 pending events, 1 mask, 2 control, 3 status (read only),
  // 4 to 7 general storage; writes to 0 and 3 are dropped
  // event bit 0 is the hook switch, bits 7:1 come from the other sources
  assign event_set = {event_in, hook_edge};

  // sticky events; a set in the clearing cycle survives
  always_comb begin
    event_next = event_reg;
    if (ev_read) begin
      event_next = 8'h00; // read clears the pending bits
    end
    // clear first, then or in the new sets, so the set wins
    event_next = event_next | event_set;
  end

  // pending events, dropped only by the event read or a reset
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      event_reg <= 8'h00;
    end else begin
      event_reg <= event_next;
    end
  end

  // writable registers, stored on the write strobe rising edge
  // select codes 0 and 3 fall into the default and are dropped
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      mask_reg <= HBI_MASK_RST;
      ctrl_reg <= HBI_CTRL_RST; // idle mode after reset
    end else if (wr_rise) begin
      case (prev_reg.sel)
        HBI_SEL_MASK: begin
          mask_reg <= prev_reg.data;
        end
        HBI_SEL_CTRL: begin
          ctrl_reg <= prev_reg.data;
        end
        default: begin
        end
      endcase
    end
  end

  // general storage behind the upper select codes
  // only the low two select bits index it, so four entries are reachable
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      for (int i = 0; i < NSCRATCH; i++) begin
        scratch_reg[i] <= HBI_SCRATCH_RST;
      end
    end else if (wr_rise && prev_reg.sel[2]) begin
      scratch_reg[prev_reg.sel[1:0]] <= prev_reg.data;
    end
  end

  assign mode_out = hbi_mode_e'(ctrl_reg[HBI_CTRL_MODE_LSB +: 2]);
  assign status_val = {5'h00, mode_out, hook2_reg};

  // read mux
  // works on the sampled select, so a select change mid-strobe is not seen
  always_comb begin
    case (sync2_reg.sel)
      HBI_SEL_EVENT:  read_val = event_reg;
      HBI_SEL_MASK:   read_val = mask_reg;
      HBI_SEL_CTRL:   read_val = ctrl_reg;
      HBI_SEL_STATUS: read_val = status_val;
      default:        read_val = scratch_reg[sync2_reg.sel[1:0]];
    endcase
  end

  // ---------------------------------------------------------------
  // bus drive
  // ---------------------------------------------------------------
  logic [7:0] rdata_reg;

  // the pins see the enable at once but the data only three clocks after
  // the read strobe falls; until then the previous read value shows, so a
  // host must not sample before that point
  // data is latched once per read, so it holds steady from then to the end of the strobe
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_fall) begin
      rdata_reg <= read_val;
    end
  end

  assign host_bus_out = rdata_reg;
  // enable straight from the pins so the bus frees without sync delay;
  // a write strobe wins if both strobes are low to avoid contention
  assign host_bus_oe = !cs_n && !rd_n && wr_n;

  // ---------------------------------------------------------------
  // frame-paced interrupt
  // ---------------------------------------------------------------
  localparam int FW = $clog2(FRAME_CYC);
  logic [FW-1:0] frame_cnt_reg;
  logic          frame_tick;
  logic          int_n_reg;

  // one tick per frame; the count restarts on either reset so the first
  // tick after release comes a full frame later
  assign frame_tick = (frame_cnt_reg == FW'(FRAME_CYC - 1));

  // free-running frame counter
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      frame_cnt_reg <= '0;
    end else if (frame_tick) begin
      frame_cnt_reg <= '0;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 1'b1;
    end
  end

  // events show on the pin only at a frame boundary; the event read frees it at once
  // a read and a tick in one cycle: the read wins, and events kept from
  // that cycle show at the next tick
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      int_n_reg <= 1'b1;
    end else if (ev_read) begin
      int_n_reg <= 1'b1;
    end else if (frame_tick) begin
      // sticky low: narrowing the mask later does not free the pin early
      int_n_reg <= int_n_reg && !(|(event_reg & mask_reg));
    end
  end

  assign int_n = int_n_reg;

  // ---------------------------------------------------------------
  // master clock
  // ---------------------------------------------------------------
  logic [HBI_DIV_W-1:0] div_cnt_reg;
  logic [HBI_DIV_W-1:0] div_top;
  logic                 mclk_reg;

  // the divider is the host's own clock source, so only the system reset
  // stops it; a device reset returns the divide select to zero, the
  // fastest rate, which keeps the host running
  // half period of 2^sel cycles; held by system reset only, not device reset
  assign div_top = HBI_DIV_W'((1 << ctrl_reg[HBI_CTRL_DIV_LSB +: 3]) - 1);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
      mclk_reg    <= 1'b0;
    end else if (div_cnt_reg >= div_top) begin
      div_cnt_reg <= '0;
      mclk_reg    <= !mclk_reg; // keeps running through device reset
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  assign mclk_out = mclk_reg;

  // the port has no mode gating: all accesses work in idle
  // the mode field leaves this block on mode_out and in status and control reads; powering blocks
  // down by mode is the job of the logic that consumes it

endmodule // hbi_host_port

// ==== hbi_host_port_props.sv ====
// checker: concurrent assertions on the host port pins
`timescale 1ns/1ps
module hbi_host_port_chk
  import hbi_pkg::*;
#(
  parameter int FRAME_CYC = HBI_FRAME_CYC
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       device_reset,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [2:0] register_select,
  input wire logic [7:0] host_bus_out,
  input wire logic       host_bus_oe,
  input wire logic       int_n,
  input wire logic       mclk_out,
  input wire hbi_mode_e  mode_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] gap_reg;
  logic [8:0]  stall_reg;
  // cycles since the last interrupt fall; a reset allows an early first fall
  always_ff @(posedge ref_clk) begin
    if (!rst_n || device_reset) gap_reg <= 16'(FRAME_CYC);
    else if ($fell(int_n)) gap_reg <= 16'h0001;
    else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
  end
  // cycles the divided clock sat still while the device reset is high
  always_ff @(posedge ref_clk) begin
    if (!device_reset || $changed(mclk_out)) stall_reg <= 9'h000;
    else stall_reg <= stall_reg + 9'h001;
  end
  // host starts a read of the event register at the pins
  sequence ev_read_start;
    $fell(rd_n) && !cs_n && register_select == HBI_SEL_EVENT;
  endsequence
  // two sync stages and the edge memory later the pin is free
  sequence int_freed;
    ##3 int_n;
  endsequence
  chk_oe_drive_read: assert property (host_bus_oe == (!cs_n && !rd_n && wr_n))
    else $error("bus drive enable does not follow the read strobe");
  chk_oe_float_idle: assert property (cs_n || rd_n |-> !host_bus_oe)
    else $error("bus driven without a selected read");
  chk_int_reset: assert property (device_reset |=> int_n)
    else $error("interrupt low after device reset");
  chk_mode_reset: assert property (device_reset |=> mode_out == HBI_MODE_IDLE)
    else $error("mode not idle during device reset");
  chk_mode_release: assert property ($fell(device_reset) |-> mode_out == HBI_MODE_IDLE)
    else $error("mode not idle at reset release");
  chk_mclk_runs: assert property (stall_reg < 9'h100)
    else $error("divided clock stopped during device reset");
  chk_int_frame_pace: assert property ($fell(int_n) |-> gap_reg >= 16'(FRAME_CYC))
    else $error("interrupt asserted twice within one frame");
  chk_int_hold_read: assert property ($rose(int_n) |-> $past(device_reset) || $past(!rst_n) ||
    $past(!cs_n && !rd_n && register_select == HBI_SEL_EVENT, 3))
    else $error("interrupt released without event read or reset");
  chk_int_read_clear: assert property (ev_read_start |-> int_freed)
    else $error("interrupt still low after the event read");
endmodule // hbi_host_port_chk
bind hbi_host_port hbi_host_port_chk #(.FRAME_CYC(FRAME_CYC)) chk_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .device_reset(device_reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .register_select(register_select), .host_bus_out(host_bus_out), .host_bus_oe(host_bus_oe),
  .int_n(int_n), .mclk_out(mclk_out), .mode_out(mode_out));

// ==== hbi_host_model.sv ====
// host processor model driving the strobed register port
`timescale 1ns/1ps
module hbi_host_model (
  input  wire logic       ref_clk,
  output logic            cs_n            = 1'b1,
  output logic            rd_n            = 1'b1,
  output logic            wr_n            = 1'b1,
  output logic      [2:0] register_select = 3'h0,
  output logic      [7:0] host_bus_in     = 8'hff,
  input  wire logic [7:0] host_bus_out,
  input  wire logic       host_bus_oe
);
  // write cycle; bus and select held 4 clocks past the rising strobe
  task automatic write(input logic [2:0] sel, input logic [7:0] d, input logic cs = 1'b1);
    @(negedge ref_clk);
    cs_n = !cs;
    register_select = sel;
    host_bus_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    wr_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    host_bus_in = ~d; // released bus must not keep the last value
    repeat (3) @(negedge ref_clk);
  endtask
  // read cycle; data taken 4 clocks after the strobe falls
  task automatic read(input logic [2:0] sel, output logic [7:0] d);
    @(negedge ref_clk);
    cs_n = 1'b0;
    register_select = sel;
    rd_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    d = host_bus_oe ? host_bus_out : 8'hzz; // an undriven bus reads as high impedance
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule // hbi_host_model

// ==== tb.sv ====
// testbench: register access, frame interrupts, device reset
`timescale 1ns/1ps
module tb;
  import hbi_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       device_reset = 1'b0;
  logic       hook_switch_in = 1'b0;
  logic       cs_n, rd_n, wr_n, host_bus_oe, int_n, mclk_out;
  logic [2:0] register_select;
  logic [7:0] host_bus_in, host_bus_out;
  hbi_mode_e  mode_out;
  int         fail_count = 0;
  int         n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  hbi_host_port #(.FRAME_CYC(20)) hbi_host_port_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .device_reset(device_reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_select(register_select), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe), .int_n(int_n), .hook_switch_in(hook_switch_in),
    .event_in(7'h00), .mclk_out(mclk_out), .mode_out(mode_out));
  hbi_host_model hbi_host_model_i (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_select(register_select), .host_bus_in(host_bus_in), .host_bus_out(host_bus_out),
    .host_bus_oe(host_bus_oe));
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [2:0] sel, input logic [7:0] exp, input string name);
    logic [7:0] d;
    hbi_host_model_i.read(sel, d);
    check(name, d, exp);
  endtask
  // bounded wait: a frame of 20 clocks plus slack
  task automatic wait_int;
    int k;
    k = 0;
    while (int_n !== 1'b0 && k < 60) begin
      @(negedge ref_clk);
      k++;
    end
    check("int_n", {7'h00, int_n}, 8'h00);
    if (int_n !== 1'b0) print_verdict(); // timeout already counted above
  endtask
  task automatic t_regs;
    check("oe", {7'h00, host_bus_oe}, 8'h00);
    check("mode", {6'h00, mode_out}, {6'h00, HBI_MODE_IDLE});
    hbi_host_model_i.write(HBI_SEL_MASK, 8'h5a);
    rd_chk(HBI_SEL_MASK, 8'h5a, "mask");
    hbi_host_model_i.write(3'h4, 8'ha5);
    hbi_host_model_i.write(3'h7, 8'h3c);
    hbi_host_model_i.write(3'h4, 8'h11, 1'b0);
    rd_chk(3'h4, 8'ha5, "scratch4");
    rd_chk(3'h7, 8'h3c, "scratch7");
    hbi_host_model_i.write(HBI_SEL_CTRL, 8'h03);
    hbi_host_model_i.write(HBI_SEL_STATUS, 8'hff);
    rd_chk(HBI_SEL_STATUS, 8'h06, "status");
  endtask
  task automatic t_irq;
    hbi_host_model_i.write(HBI_SEL_MASK, 8'h01);
    hook_switch_in = 1'b1;
    wait_int();
    repeat (45) @(negedge ref_clk);
    check("int_hold", {7'h00, int_n}, 8'h00);
    rd_chk(HBI_SEL_EVENT, 8'h01, "events");
    check("int_clr", {7'h00, int_n}, 8'h01);
    hook_switch_in = 1'b0;
    wait_int();
  endtask
  task automatic t_dev_reset;
    logic m;
    device_reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    m = mclk_out;
    @(negedge ref_clk);
    check("mclk_run", {7'h00, mclk_out}, {7'h00, !m});
    repeat (7) @(negedge ref_clk);
    device_reset = 1'b0;
    check("int_rst", {7'h00, int_n}, 8'h01);
    check("mode_rst", {6'h00, mode_out}, {6'h00, HBI_MODE_IDLE});
    rd_chk(HBI_SEL_MASK, HBI_MASK_RST, "mask_rst");
    rd_chk(HBI_SEL_EVENT, 8'h00, "ev_rst");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    t_regs();
    t_irq();
    t_dev_reset();
    print_verdict();
  end
endmodule // tb
